/* octal_spi_ctrl.v */
// Behaviour
// - Direct mode only with serial setting high; command mode always available.
// - Direct mode takes shifted bits straight as levels or config in 8-bit frames; 16-bit frames use bit pairs.
// - New output states take effect only after chip select rises.
// - Diagnostics captured at chip select fall, shifted out on falling clock edges.
// - Command mode returns data selected by a command during the next frame.
// - Command mode always uses 16-bit frames: command byte then data byte.
// - Level LEDs of fault-free channels show slow mode when serial setting and config high, else output level.
// - Serial setting low: levels from input pins only; command frames still work.
// - In direct mode config select chooses level writes or driver mode writes.
// - Direct configuration writes leave every output level unchanged.
// - Direct 16-bit config accepts open-load enable; returns fault and slow mode.
// - Direct 16-bit config frame returns fault bit paired with slow mode bit.
// - Level 1 turns high side on, low side off; 0 the reverse in push-pull.
// - Direct 8-bit config: bit 0 means high-side, bit 1 means push-pull.
// - Fault bit is 1 on thermal shutdown or open load, else 0.
// - Direct 8-bit frames return the eight per-channel fault bits.
// - Global fault output is the live OR of channel faults, not latched.
// - Serial output repeats serial input delayed by one frame for daisy chains.
// - Clock idles low; input sampled on rising, output changed on falling edges.
// - Serial output driven only while chip select low, otherwise released.
// - Serial setting low: each channel follows its own input pin.
`timescale 1ns/1ps
`include "octal_spi_regs.vh"

module frame_queue #(
    parameter W = `WORD_WIDTH,
    parameter DEPTH = `QUEUE_DEPTH,
    parameter AW = `QUEUE_ADDR_W
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_q];

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // frame_queue

module octal_spi_ctrl (
    // Clock and reset
    input wire CLOCK,
    input wire RSTN,
    // Serial link pins
    input wire CS_N,
    input wire SCLK,
    input wire SDI,
    output wire SDO,
    output wire SDO_OE_N,
    // Strap and setting pins
    input wire SERIAL_SETTING_SELECT,
    input wire COMMAND_MODE_SELECT,
    input wire CONFIG_SELECT,
    input wire FRAME16_SELECT,
    input wire [7:0] CHANNEL_INPUT,
    input wire HOLD_OUTPUTS,
    // Channel status from the driver stage
    input wire [7:0] THERMAL_SHUTDOWN,
    input wire [7:0] OPEN_LOAD_FAULT,
    input wire [7:0] SLOW_MODE,
    input wire [7:0] OUT_LEVEL,
    // Driver controls and indicators
    output wire [7:0] HIGH_SIDE_SWITCH,
    output wire [7:0] LOW_SIDE_SWITCH,
    output wire [7:0] PUSH_PULL_MODE,
    output wire [7:0] OPEN_LOAD_DETECT,
    output wire [7:0] LEVEL_LED,
    output wire FAULT,
    output wire FRAME_LOST
);
    // Readback select for command mode
    function [7:0] readback;
        input [2:0] addr;
        input [7:0] lvl, pp, ol_en, thsd, olf, slow, outl;
        begin
            case (addr)
                `ADDR_LEVEL: readback = lvl;
                `ADDR_PUSHPULL: readback = pp;
                `ADDR_OPENLOAD_EN: readback = ol_en;
                `ADDR_THERMAL: readback = thsd;
                `ADDR_OPENLOAD: readback = olf;
                `ADDR_SLOW: readback = slow;
                `ADDR_OUT_LEVEL: readback = outl;
                default: readback = 8'h00;
            endcase
        end
    endfunction

    // Three-stage sampling of the link, strap and channel input pins; driver status inputs are not sampled
    wire [15:0] raw = {HOLD_OUTPUTS, CHANNEL_INPUT, FRAME16_SELECT, CONFIG_SELECT,
                       COMMAND_MODE_SELECT, SERIAL_SETTING_SELECT, SDI, SCLK, CS_N};
    reg [15:0] s1_q;
    reg [15:0] s2_q;
    reg [15:0] s3_q;
    reg [15:0] filt_q;
    reg [15:0] prev_q;
    localparam [15:0] sync_init = `SYNC_RESET;
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : sync
            always @(posedge CLOCK or negedge RSTN) begin
                if (!RSTN) begin
                    s1_q[g] <= sync_init[g];
                    s2_q[g] <= sync_init[g];
                    s3_q[g] <= sync_init[g];
                    filt_q[g] <= sync_init[g];
                    prev_q[g] <= sync_init[g];
                end else begin
                    s1_q[g] <= raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // A change counts only once stages two and three agree
                    if (s2_q[g] == s3_q[g]) begin
                        filt_q[g] <= s3_q[g];
                    end
                    prev_q[g] <= filt_q[g];
                end
            end
        end
    endgenerate

    wire cs_n = filt_q[0];
    wire sdi_f = filt_q[2];
    wire serial = filt_q[3];
    wire cmd_sel = filt_q[4];
    wire cfg_sel = filt_q[5];
    wire f16_sel = filt_q[6];
    wire [7:0] chan_in = filt_q[14:7];
    wire hold = filt_q[15];
    wire cs_fall = prev_q[0] & ~filt_q[0];
    wire cs_rise = ~prev_q[0] & filt_q[0];
    wire sclk_rise = ~prev_q[1] & filt_q[1];
    wire sclk_fall = prev_q[1] & ~filt_q[1];

    // Settings and live status
    reg [7:0] level_q;
    reg [7:0] pp_q;
    reg [7:0] ol_en_q;
    wire [7:0] chan_fault = THERMAL_SHUTDOWN | OPEN_LOAD_FAULT;
    wire is_direct = serial & ~cmd_sel;
    wire is_f16 = ~is_direct | f16_sel;
    wire led_slow = serial & cfg_sel;

    // Frame engine
    reg active_q;
    reg [4:0] cnt_q;
    reg [15:0] rx_q;
    reg [15:0] sr_q;
    reg sdi_hold_q;
    reg direct_q;
    reg f16_q;
    reg cfg_q;
    reg [2:0] rd_sel_q;
    reg [15:0] diag16;
    integer i;
    integer j;
    integer k;

    always @* begin
        diag16 = 16'h0000;
        for (i = 0; i < 8; i = i + 1) begin
            diag16[2*i+1] = chan_fault[i];
            diag16[2*i] = cfg_sel ? SLOW_MODE[i] : OUT_LEVEL[i];
        end
    end

    wire [4:0] frame_bits = f16_q ? `FRAME16_BITS : `FRAME8_BITS;
    wire sr_msb = f16_q ? sr_q[15] : sr_q[7];

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            active_q <= 1'b0;
            cnt_q <= 5'h00;
            rx_q <= 16'h0000;
            sr_q <= 16'h0000;
            sdi_hold_q <= 1'b0;
            direct_q <= 1'b0;
            f16_q <= 1'b1;
            cfg_q <= 1'b0;
            rd_sel_q <= 3'h0;
        end else if (cs_fall) begin
            active_q <= 1'b1;
            cnt_q <= 5'h00;
            direct_q <= is_direct;
            f16_q <= is_f16;
            cfg_q <= cfg_sel;
            // Status is frozen here for the whole frame
            if (!is_direct) begin
                sr_q <= {chan_fault, readback(rd_sel_q, level_q, pp_q, ol_en_q, THERMAL_SHUTDOWN,
                                              OPEN_LOAD_FAULT, SLOW_MODE, OUT_LEVEL)};
            end else if (f16_sel) begin
                sr_q <= diag16;
            end else begin
                sr_q <= {8'h00, chan_fault};
            end
        end else if (cs_rise) begin
            active_q <= 1'b0;
            if (!direct_q && active_q && cnt_q >= frame_bits) begin
                rd_sel_q <= rx_q[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            end
        end else if (active_q) begin
            if (sclk_rise) begin
                rx_q <= {rx_q[14:0], sdi_f};
                sdi_hold_q <= sdi_f;
                if (cnt_q != `COUNT_MAX) begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
            if (sclk_fall) begin
                // Received bits follow the status out, so a chain sees them one frame later
                sr_q <= {sr_q[14:0], sdi_hold_q};
            end
        end
    end

    // Completed frames are queued and applied only after chip select rises
    wire push = cs_rise & active_q & (cnt_q >= frame_bits);
    wire q_ready;
    wire q_valid;
    wire [`WORD_WIDTH-1:0] qw;
    wire pop = q_valid & ~hold;

    frame_queue #(
        .W(`WORD_WIDTH),
        .DEPTH(`QUEUE_DEPTH),
        .AW(`QUEUE_ADDR_W)
    ) queue (
        .clk(CLOCK),
        .rst_n(RSTN),
        .in_data({direct_q, cfg_q, f16_q, rx_q}),
        .in_valid(push),
        .in_ready(q_ready),
        .out_data(qw),
        .out_valid(q_valid),
        .out_ready(~hold)
    );

    reg [7:0] d_bits;
    reg [7:0] c_bits;
    always @* begin
        d_bits = 8'h00;
        c_bits = 8'h00;
        for (j = 0; j < 8; j = j + 1) begin
            d_bits[j] = qw[2*j+1];
            c_bits[j] = qw[2*j];
        end
    end

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            level_q <= `LEVEL_RESET;
            pp_q <= `PUSHPULL_RESET;
            ol_en_q <= `OPENLOAD_EN_RESET;
        end else if (pop) begin
            if (qw[`WORD_DIRECT_BIT]) begin
                if (!qw[`WORD_F16_BIT]) begin
                    if (qw[`WORD_CFG_BIT]) begin
                        pp_q <= qw[7:0];
                    end else begin
                        level_q <= qw[7:0];
                    end
                end else if (qw[`WORD_CFG_BIT]) begin
                    for (k = 0; k < 8; k = k + 1) begin
                        // Pair 11 is unused and leaves the channel as it was
                        if (!(d_bits[k] & c_bits[k])) begin
                            pp_q[k] <= c_bits[k];
                            ol_en_q[k] <= d_bits[k];
                        end
                    end
                end else begin
                    level_q <= d_bits;
                    pp_q <= c_bits;
                end
            end else if (qw[`CMD_WRITE_BIT]) begin
                case (qw[`CMD_ADDR_MSB:`CMD_ADDR_LSB])
                    `ADDR_LEVEL: level_q <= qw[7:0];
                    `ADDR_PUSHPULL: pp_q <= qw[7:0];
                    `ADDR_OPENLOAD_EN: ol_en_q <= qw[7:0];
                    default: level_q <= level_q;
                endcase
            end
        end
    end

    // Output registers
    reg sdo_q;
    reg sdo_oe_n_q;
    reg [7:0] hs_q;
    reg [7:0] ls_q;
    reg [7:0] pp_out_q;
    reg [7:0] old_q;
    reg [7:0] led_q;
    reg fault_q;
    reg lost_q;
    wire [7:0] eff_level = serial ? level_q : chan_in;

    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            sdo_q <= 1'b0;
            sdo_oe_n_q <= 1'b1;
            hs_q <= 8'h00;
            ls_q <= 8'h00;
            pp_out_q <= 8'h00;
            old_q <= 8'h00;
            led_q <= 8'h00;
            fault_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            sdo_q <= ~cs_n & active_q & sr_msb;
            sdo_oe_n_q <= cs_n;
            hs_q <= eff_level;
            ls_q <= pp_q & ~eff_level;
            pp_out_q <= pp_q;
            old_q <= ol_en_q & ~pp_q;
            // A faulted channel never shows its level indicator
            led_q <= (led_slow ? SLOW_MODE : OUT_LEVEL) & ~chan_fault;
            fault_q <= |chan_fault;
            lost_q <= push & ~q_ready;
        end
    end

    assign SDO = sdo_q;
    assign SDO_OE_N = sdo_oe_n_q;
    assign HIGH_SIDE_SWITCH = hs_q;
    assign LOW_SIDE_SWITCH = ls_q;
    assign PUSH_PULL_MODE = pp_out_q;
    assign OPEN_LOAD_DETECT = old_q;
    assign LEVEL_LED = led_q;
    assign FAULT = fault_q;
    assign FRAME_LOST = lost_q;
endmodule // octal_spi_ctrl

/* octal_spi_regs.vh */
`ifndef OCTAL_SPI_REGS_VH
`define OCTAL_SPI_REGS_VH

// Frame lengths and bit counter
`define FRAME8_BITS 5'h08
`define FRAME16_BITS 5'h10
`define COUNT_MAX 5'h1F

// Frame word as queued towards the output stage
`define WORD_WIDTH 19
`define WORD_DIRECT_BIT 18
`define WORD_CFG_BIT 17
`define WORD_F16_BIT 16

// Command frame fields, inside the 16 received bits
`define CMD_WRITE_BIT 14
`define CMD_ADDR_MSB 10
`define CMD_ADDR_LSB 8

// Command mode register addresses
`define ADDR_LEVEL 3'h0
`define ADDR_PUSHPULL 3'h1
`define ADDR_OPENLOAD_EN 3'h2
`define ADDR_THERMAL 3'h3
`define ADDR_OPENLOAD 3'h4
`define ADDR_SLOW 3'h5
`define ADDR_OUT_LEVEL 3'h7

// Reset values
`define LEVEL_RESET 8'h00
`define PUSHPULL_RESET 8'h00
`define OPENLOAD_EN_RESET 8'h00
`define SYNC_RESET 16'h0001

// Frame queue
`define QUEUE_DEPTH 16
`define QUEUE_ADDR_W 4

`endif

/* octal_spi_ctrl_assertions.sv */
`timescale 1ns/1ps
module octal_spi_checker (
    // Clock and reset
    input wire CLOCK,
    input wire RSTN,
    // Link, straps and pins
    input wire CS_N,
    input wire SDO,
    input wire SDO_OE_N,
    input wire SERIAL_SETTING_SELECT,
    input wire CONFIG_SELECT,
    input wire HOLD_OUTPUTS,
    input wire [7:0] CHANNEL_INPUT,
    // Status and driver controls
    input wire [7:0] THERMAL_SHUTDOWN,
    input wire [7:0] OPEN_LOAD_FAULT,
    input wire [7:0] SLOW_MODE,
    input wire [7:0] HIGH_SIDE_SWITCH,
    input wire [7:0] LOW_SIDE_SWITCH,
    input wire [7:0] PUSH_PULL_MODE,
    input wire [7:0] OPEN_LOAD_DETECT,
    input wire [7:0] LEVEL_LED,
    input wire FAULT
);
    wire [7:0] flt = THERMAL_SHUTDOWN | OPEN_LOAD_FAULT;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    // Pins pass a three-stage synchroniser, so every window allows for that lag
    sequence cs_idle;
        CS_N [*8];
    endsequence
    sequence cs_busy;
        !CS_N [*8];
    endsequence
    sequence slow_shown;
        (SERIAL_SETTING_SELECT && CONFIG_SELECT) [*6];
    endsequence
    sequence pins_steady;
        (!SERIAL_SETTING_SELECT && $stable(CHANNEL_INPUT)) [*6];
    endsequence
    sequence frame_open;
        (SERIAL_SETTING_SELECT && !CS_N && !HOLD_OUTPUTS) [*8];
    endsequence
    AST_SDO_RELEASED: assert property (cs_idle |-> SDO_OE_N && !SDO)
        else $error("serial output driven while deselected");
    AST_SDO_DRIVEN: assert property (cs_busy |-> !SDO_OE_N)
        else $error("serial output idle inside frame");
    AST_FAULT_LIVE: assert property ($past(RSTN) |-> FAULT == |$past(flt))
        else $error("fault pin is not the live OR");
    AST_LOW_SIDE: assert property (LOW_SIDE_SWITCH == (PUSH_PULL_MODE & ~HIGH_SIDE_SWITCH))
        else $error("low side switch wrong");
    AST_OPEN_LOAD_HS: assert property ((OPEN_LOAD_DETECT & PUSH_PULL_MODE) == 8'h00)
        else $error("open load detect on push-pull channel");
    AST_LED_SLOW: assert property (slow_shown |=> LEVEL_LED == ($past(SLOW_MODE) & ~$past(flt)))
        else $error("level indicator not showing slow mode");
    AST_PIN_LEVEL: assert property (pins_steady |=> HIGH_SIDE_SWITCH == $past(CHANNEL_INPUT))
        else $error("channel not following its input pin");
    AST_FRAME_HOLD: assert property (frame_open |=> $stable(HIGH_SIDE_SWITCH) && $stable(PUSH_PULL_MODE))
        else $error("outputs changed inside a frame");
endmodule // octal_spi_checker

bind octal_spi_ctrl octal_spi_checker u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .CS_N(CS_N), .SDO(SDO),
    .SDO_OE_N(SDO_OE_N), .SERIAL_SETTING_SELECT(SERIAL_SETTING_SELECT), .CONFIG_SELECT(CONFIG_SELECT),
    .HOLD_OUTPUTS(HOLD_OUTPUTS), .CHANNEL_INPUT(CHANNEL_INPUT), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
    .OPEN_LOAD_FAULT(OPEN_LOAD_FAULT), .SLOW_MODE(SLOW_MODE), .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH),
    .LOW_SIDE_SWITCH(LOW_SIDE_SWITCH), .PUSH_PULL_MODE(PUSH_PULL_MODE), .OPEN_LOAD_DETECT(OPEN_LOAD_DETECT),
    .LEVEL_LED(LEVEL_LED), .FAULT(FAULT));

/* spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
    // System clock
    input wire clk,
    // Serial link
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire sdo
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end
    // Eight system clocks per half of the 80 ns link period
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (8) @(posedge clk);
            rx = {rx[14:0], sdo};
            sclk <= 1'b1;
            repeat (8) @(posedge clk);
            sclk <= 1'b0;
        end
        // A released data line must not keep looking like the last bit
        sdi <= ~tx[0];
        repeat (8) @(posedge clk);
        cs_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
endmodule // spi_host_model

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic srl = 1'b0;
    logic cmd = 1'b0;
    logic cfg = 1'b0;
    logic f16 = 1'b0;
    logic hold = 1'b0;
    logic [7:0] chin = 8'h00;
    logic [7:0] thsd = 8'h81;
    logic [7:0] olf = 8'h02;
    logic [7:0] slow = 8'h11;
    logic [15:0] rx;
    wire cs_n, sclk, sdi, sdo, sdo_oe_n, fault, lost;
    wire [7:0] hs, ls, pp, old, led;
    // Weak pull-down on the serial output while deselected
    wire sdo_line = sdo_oe_n ? 1'b0 : sdo;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_lost = 0;
    octal_spi_ctrl u_dut (.CLOCK(clock), .RSTN(rstn), .CS_N(cs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
        .SDO_OE_N(sdo_oe_n), .SERIAL_SETTING_SELECT(srl), .COMMAND_MODE_SELECT(cmd), .CONFIG_SELECT(cfg),
        .FRAME16_SELECT(f16), .CHANNEL_INPUT(chin), .HOLD_OUTPUTS(hold), .THERMAL_SHUTDOWN(thsd),
        .OPEN_LOAD_FAULT(olf), .SLOW_MODE(slow), .OUT_LEVEL(hs), .HIGH_SIDE_SWITCH(hs), .LOW_SIDE_SWITCH(ls),
        .PUSH_PULL_MODE(pp), .OPEN_LOAD_DETECT(old), .LEVEL_LED(led), .FAULT(fault), .FRAME_LOST(lost));
    spi_host_model u_host (.clk(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (lost === 1'b1)
            n_lost <= n_lost + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    // Straps pass a synchroniser, so settle them well before a frame
    task automatic mode(input logic [3:0] m);
        @(posedge clock);
        srl <= m[3];
        cmd <= m[2];
        cfg <= m[1];
        f16 <= m[0];
        repeat (8) @(posedge clock);
    endtask
    task automatic t_parallel();
        mode(4'b0000);
        chin <= 8'ha5;
        repeat (8) @(posedge clock);
        chk("hs", 16'h00a5, hs);
        u_host.xfer(16'h400f, 16, rx);
        chk("hs", 16'h00a5, hs);
    endtask
    task automatic t_direct8();
        mode(4'b1000);
        u_host.xfer(16'h003c, 8, rx);
        chk("sdo", 16'h0083, rx);
        chk("hs", 16'h003c, hs);
        chk("fault", 16'h0001, fault);
        chk("led", 16'h003c, led);
    endtask
    task automatic t_config8();
        mode(4'b1010);
        u_host.xfer(16'h00f0, 8, rx);
        chk("pp", 16'h00f0, pp);
        chk("hs", 16'h003c, hs);
        chk("ls", 16'h00c0, ls);
    endtask
    task automatic t_daisy();
        mode(4'b1000);
        u_host.xfer(16'h5ac3, 16, rx);
        chk("sdo", 16'h835a, rx);
        chk("hs", 16'h00c3, hs);
    endtask
    task automatic t_direct16();
        logic [15:0] exp;
        mode(4'b1011);
        u_host.xfer(16'h0006, 16, rx);
        for (int i = 0; i < 8; i++) begin
            exp[2 * i + 1] = thsd[i] | olf[i];
            exp[2 * i] = slow[i];
        end
        chk("sdo", exp, rx);
        chk("pp", 16'h0002, pp);
        chk("old", 16'h0001, old);
    endtask
    // Level frame: channels keep 8'hc3 from the chain test until this frame lands
    task automatic t_level16();
        logic [15:0] exp;
        logic [7:0] lvl;
        lvl = 8'hc3;
        mode(4'b1001);
        u_host.xfer(16'h0027, 16, rx);
        for (int i = 0; i < 8; i++) begin
            exp[2 * i + 1] = thsd[i] | olf[i];
            exp[2 * i] = lvl[i];
        end
        chk("sdo", exp, rx);
        chk("hs", 16'h0005, hs);
        chk("pp", 16'h0003, pp);
        chk("ls", 16'h0002, ls);
    endtask
    task automatic t_command();
        mode(4'b1110);
        u_host.xfer(16'h4099, 16, rx);
        chk("hs", 16'h0099, hs);
        u_host.xfer(16'h0100, 16, rx);
        chk("sdo", 16'h8399, rx);
        u_host.xfer(16'h0000, 16, rx);
        chk("sdo", 16'h8303, rx);
        chk("led", 16'h0010, led);
    endtask
    task automatic t_hold();
        mode(4'b1000);
        hold <= 1'b1;
        for (int i = 0; i < 17; i++)
            u_host.xfer({8'h00, i[7:0]}, 8, rx);
        chk("hs", 16'h0099, hs);
        chk("lost", 16'h0001, n_lost[15:0]);
        hold <= 1'b0;
        repeat (40) @(posedge clock);
        chk("hs", 16'h000f, hs);
        thsd <= 8'h00;
        olf <= 8'h00;
        repeat (3) @(posedge clock);
        chk("fault", 16'h0000, fault);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (6) @(posedge clock);
        t_parallel();
        t_direct8();
        t_config8();
        t_daisy();
        t_direct16();
        t_level16();
        t_command();
        t_hold();
        summarize();
    end
endmodule // tb_top
